// File: dv/drive_stop_option_selector_test.sv
module drive_stop_option_selector_test;
    timeunit 1ns;
    timeprecision 100ps;
    import dsos_pkg::*;
    localparam logic [17:0] AQ = 18'h18168;
    localparam logic [17:0] AS = 18'h1816c;
    localparam logic [17:0] AD = 18'h18170;
    localparam logic [17:0] AH = 18'h18174;
    localparam logic [17:0] AF = 18'h18178;
    localparam logic [17:0] AN = 18'h18400;
    localparam logic [17:0] AE = 18'h18404;
    localparam logic [17:0] AT = 18'h18408;
    logic i_mclk = 1'b0;
    logic i_reset_n = 1'b0;
    dsos_bus_t bus;
    logic [31:0] rdata;
    dsos_evt_t evt = '0;
    logic [15:0] cw = 16'h0;
    logic stand = 1'b0;
    logic sst = 1'b0;
    logic signed [31:0] sin = 32'sh0;
    logic busy, done, halt, stop, dis;
    logic signed [31:0] suser;
    dsos_act_t act;
    int errors = 0;
    int total_checks = 0;
    logic [31:0] v;
    initial forever #12.5 i_mclk = ~i_mclk;
    dsos_master m_u (.i_mclk(i_mclk), .o_bus(bus), .i_rdata(rdata));
    dsos_selector dut_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_bus(bus), .o_rdata(rdata), .i_evt(evt), .i_ctrl_word(cw),
        .i_standstill(stand), .i_speed_start(sst),
        .i_speed_internal(sin), .o_speed_busy(busy),
        .o_speed_done(done), .o_speed_user(suser), .o_act(act),
        .o_halt_active(halt), .o_stop_active(stop),
        .o_enter_disabled(dis));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // bounded wait: 0 stop, 1 halt, 2 done
    task automatic wt(input int sel, input logic lv);
        for (int n = 0; n < 100; n++) begin
            @(posedge i_mclk);
            #1;
            if ((sel == 0 ? stop : sel == 1 ? halt : done) === lv) return;
        end
        errors++;
        conclude();
    endtask : wt
    task automatic rst;
        @(posedge i_mclk) i_reset_n <= 1'b0;
        repeat (5) @(posedge i_mclk);
        i_reset_n <= 1'b1;
    endtask : rst
    task automatic wr_rd(input logic [17:0] a, input logic [31:0] d, e);
        m_u.wr(a, d);
        m_u.rd(a, v);
        chk(v, e);
    endtask : wr_rd
    task automatic rd_chk(input logic [17:0] a, input logic [31:0] e);
        m_u.rd(a, v);
        chk(v, e);
    endtask : rd_chk
    task automatic ev(input int k, input logic [17:0] a, input logic [15:0] c,
                      input dsos_ramp_t r, input dsos_end_t f);
        logic [31:0] st;
        st = {24'h0, r, f, r != DSOS_RAMP_IMM, f == DSOS_END_QSA, 2'h1};
        m_u.wr(a, {16'h0, c});
        @(posedge i_mclk) evt <= dsos_evt_t'(4'b0001 << k);
        wt(0, 1'b1);
        chk({28'h0, act.ramp, act.final_state}, {28'h0, r, f});
        if (f == DSOS_END_QSA) chk({30'h0, act.energized, act.allow_reenable}, 32'h3);
        rd_chk(AT, st);
        @(posedge i_mclk) stand <= 1'b1;
        wt(0, 1'b0);
        chk({31'h0, dis}, {31'h0, f == DSOS_END_SOD});
        @(posedge i_mclk) begin
            evt <= '0;
            stand <= 1'b0;
        end
        repeat (4) @(posedge i_mclk);
    endtask : ev
    task automatic hl(input logic [15:0] c, input dsos_ramp_t r);
        m_u.wr(AH, {16'h0, c});
        @(posedge i_mclk) cw <= 16'h0100;
        wt(1, 1'b1);
        chk({30'h0, act.ramp}, {30'h0, r});
        @(posedge i_mclk) cw <= 16'h0;
        wt(1, 1'b0);
    endtask : hl
    task automatic sp(input logic signed [31:0] x, n, d, e);
        m_u.wr(AN, n);
        m_u.wr(AE, d);
        @(posedge i_mclk) begin
            sin <= x;
            sst <= 1'b1;
        end
        @(posedge i_mclk) sst <= 1'b0;
        #1 chk({31'h0, busy}, 32'h1);
        wt(2, 1'b1);
        chk(suser, e);
    endtask : sp
    initial begin
        rst();
        rd_chk(AQ, 32'h2);
        rd_chk(AS, 32'h1);
        rd_chk(AD, 32'h1);
        rd_chk(AH, 32'h1);
        rd_chk(AF, 32'h2);
        rd_chk(AN, 32'h1);
        rd_chk(AE, 32'h1);
        wr_rd(AQ, 32'h5, 32'h5);
        wr_rd(AQ, 32'h3, 32'h5);
        wr_rd(AQ + 18'h1, 32'h0, 32'h0);
        rd_chk(AQ, 32'h5);
        wr_rd(AH, 32'h0, 32'h1);
        wr_rd(AS, 32'h2, 32'h1);
        wr_rd(AF, 32'h3, 32'h2);
        wr_rd(18'h00100, 32'h7, 32'h0);
        ev(3, AQ, 16'h5, DSOS_RAMP_SLOW, DSOS_END_QSA);
        ev(3, AQ, 16'h6, DSOS_RAMP_QUICK, DSOS_END_QSA);
        ev(0, AF, 16'h0, DSOS_RAMP_IMM, DSOS_END_NONE);
        ev(0, AF, 16'h1, DSOS_RAMP_SLOW, DSOS_END_NONE);
        ev(0, AF, 16'h2, DSOS_RAMP_QUICK, DSOS_END_NONE);
        ev(3, AQ, 16'h0, DSOS_RAMP_IMM, DSOS_END_SOD);
        ev(3, AQ, 16'h1, DSOS_RAMP_SLOW, DSOS_END_SOD);
        ev(3, AQ, 16'h2, DSOS_RAMP_QUICK, DSOS_END_SOD);
        ev(2, AS, 16'h0, DSOS_RAMP_IMM, DSOS_END_SOD);
        ev(2, AS, 16'h1, DSOS_RAMP_SLOW, DSOS_END_SOD);
        ev(1, AD, 16'h0, DSOS_RAMP_IMM, DSOS_END_SOD);
        ev(1, AD, 16'h1, DSOS_RAMP_SLOW, DSOS_END_SOD);
        hl(16'h1, DSOS_RAMP_SLOW);
        hl(16'h2, DSOS_RAMP_QUICK);
        sp(32'hffff_fff9, 32'h3c, 32'h1, 32'hffff_fe5c);
        sp(32'h7, 32'h3, 32'h2, 32'ha);
        sp(32'hffff_fff9, 32'h3, 32'h2, 32'hffff_fff6);
        sp(32'h5, 32'h1, 32'h0, 32'h0);
        rst();
        rd_chk(AQ, 32'h2);
        rd_chk(AH, 32'h1);
        rd_chk(AE, 32'h1);
        conclude();
    end
endmodule : drive_stop_option_selector_test

// File: dv/dsos_master.sv
module dsos_master (
    // clock
    input wire logic i_mclk,
    // register port
    output dsos_pkg::dsos_bus_t o_bus,
    input wire logic [31:0] i_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    import dsos_pkg::*;
    initial o_bus = '0;
    // released lines show the inverse of the last value
    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_mclk);
        o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr
    task automatic rd(input logic [17:0] a, output logic [31:0] d);
        @(posedge i_mclk);
        o_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk);
        o_bus <= '{addr: ~a, wdata: ~32'h0, wr: 1'b0, rd: 1'b0};
        #1 d = i_rdata;
    endtask : rd
endmodule : dsos_master

// File: dv/dsos_sva.sv
module dsos_sva (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // register port
    input wire dsos_pkg::dsos_bus_t i_bus,
    input wire logic [31:0] o_rdata,
    // events
    input wire dsos_pkg::dsos_evt_t i_evt,
    input wire logic [15:0] i_ctrl_word,
    input wire logic i_standstill,
    // speed
    input wire logic i_speed_start,
    input wire logic signed [31:0] i_speed_internal,
    input wire logic o_speed_busy,
    input wire logic o_speed_done,
    input wire logic signed [31:0] o_speed_user,
    // action
    input wire dsos_pkg::dsos_act_t o_act,
    input wire logic o_halt_active,
    input wire logic o_stop_active,
    input wire logic o_enter_disabled
);
    timeunit 1ns;
    timeprecision 100ps;
    import dsos_pkg::*;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);
    AST_QSA_ON: assert property (o_act.final_state == DSOS_END_QSA
        |-> o_act.energized && o_act.allow_reenable)
        else $error("hold stop not energized");
    AST_SOD_NO_RET: assert property (o_act.final_state == DSOS_END_SOD
        |-> !o_act.allow_reenable)
        else $error("disabled end allows return");
    AST_DIS_AFTER: assert property ($rose(o_enter_disabled)
        |-> $past(o_stop_active) && o_act.final_state == DSOS_END_SOD)
        else $error("disable request without stop");
    AST_STOP_RAMP: assert property ($rose(o_stop_active)
        |-> o_act.ramp != DSOS_RAMP_NONE)
        else $error("stop without ramp");
    AST_HALT_RAMP: assert property ($rose(o_halt_active)
        |-> o_act.ramp inside {DSOS_RAMP_SLOW, DSOS_RAMP_QUICK})
        else $error("halt ramp wrong");
    AST_HALT_BIT: assert property ($rose(i_ctrl_word[8]) && !o_stop_active
        |-> ##[1:6] o_halt_active)
        else $error("halt not taken");
    AST_HALT_LOCK: assert property (o_stop_active |-> !$rose(o_halt_active))
        else $error("halt during stop");
    AST_SPD_RUN: assert property (i_speed_start && !o_speed_busy
        |=> o_speed_busy ##[1:70] o_speed_done)
        else $error("conversion did not finish");
    AST_DONE_ONE: assert property (o_speed_done |=> !o_speed_done)
        else $error("done longer than one cycle");
    AST_RD_QUIET: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
        else $error("read data outside read cycle");
    cover property ($rose(o_enter_disabled));
    cover property ($rose(o_halt_active));
    cover property (o_speed_done);
    cover property (o_stop_active && o_act.final_state == DSOS_END_QSA);
endmodule : dsos_sva

bind dsos_selector dsos_sva chk_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_bus(i_bus), .o_rdata(o_rdata), .i_evt(i_evt),
    .i_ctrl_word(i_ctrl_word), .i_standstill(i_standstill),
    .i_speed_start(i_speed_start), .i_speed_internal(i_speed_internal),
    .o_speed_busy(o_speed_busy), .o_speed_done(o_speed_done),
    .o_speed_user(o_speed_user), .o_act(o_act),
    .o_halt_active(o_halt_active), .o_stop_active(o_stop_active),
    .o_enter_disabled(o_enter_disabled));

// File: rtl/dsos_code_reg.sv
`include "dsos_regs.svh"
module dsos_code_reg #(
    parameter logic [15:0] RESET_VAL = 16'h0000,
    parameter logic [6:0] VALID_MASK = 7'h00
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // write port
    input wire logic i_wr,
    input wire logic [15:0] i_wdata,
    // stored code
    output logic [15:0] o_code
);
    logic valid;

    always_comb begin
        valid = 1'b0;
        if (i_wdata < 16'h0007) begin
            valid = VALID_MASK[i_wdata[2:0]];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_code <= RESET_VAL;
        end else if (i_wr && valid) begin
            o_code <= i_wdata; // RQ13
        end
    end
endmodule : dsos_code_reg

// File: rtl/dsos_pkg.sv
package dsos_pkg;
    typedef enum logic [1:0] {
        DSOS_RAMP_NONE,
        DSOS_RAMP_IMM,
        DSOS_RAMP_SLOW,
        DSOS_RAMP_QUICK
    } dsos_ramp_t;

    typedef enum logic [1:0] {
        DSOS_END_NONE,
        DSOS_END_SOD,
        DSOS_END_QSA
    } dsos_end_t;

    typedef struct packed {
        logic qstop;
        logic shutdown;
        logic disable_op;
        logic fault;
    } dsos_evt_t;

    typedef struct packed {
        dsos_ramp_t ramp;
        dsos_end_t final_state;
        logic energized;
        logic allow_reenable;
    } dsos_act_t;

    typedef struct packed {
        logic [17:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dsos_bus_t;
endpackage : dsos_pkg

// File: rtl/dsos_regs.svh
`ifndef DSOS_REGS_SVH
`define DSOS_REGS_SVH
// register indices; the bus byte address is four times the index
`define DSOS_IDX_QSTOP 16'h605a
`define DSOS_IDX_SHUT 16'h605b
`define DSOS_IDX_DIS 16'h605c
`define DSOS_IDX_HALT 16'h605d
`define DSOS_IDX_FAULT 16'h605e
`define DSOS_IDX_SPD_NUM 16'h6100
`define DSOS_IDX_SPD_DEN 16'h6101
`define DSOS_IDX_STATUS 16'h6102
`define DSOS_ADDR(i) {(i), 2'b00}
// reset values
`define DSOS_RST_QSTOP 16'h0002
`define DSOS_RST_SHUT 16'h0001
`define DSOS_RST_DIS 16'h0001
`define DSOS_RST_HALT 16'h0001
`define DSOS_RST_FAULT 16'h0002
`define DSOS_RST_SPD_NUM 32'h0000_0001
`define DSOS_RST_SPD_DEN 32'h0000_0001
// option codes
`define DSOS_CODE_IMM 16'h0000
`define DSOS_CODE_SLOW 16'h0001
`define DSOS_CODE_QUICK 16'h0002
`define DSOS_CODE_SLOW_HOLD 16'h0005
`define DSOS_CODE_QUICK_HOLD 16'h0006
// control word halt bit
`define DSOS_CW_HALT_BIT 8
`endif

// File: rtl/dsos_selector.sv
`include "dsos_regs.svh"
// Functional notes
// [RQ1] speed scaled by numerator over denominator
// [RQ2] quick stop 0: immediate stop, then disabled
// [RQ3] quick stop 1: slow ramp, then disabled
// [RQ4] quick stop 2: quick ramp, then disabled
// [RQ5] codes 5/6: ramp, stay energized in quick-stop
// [RQ6] codes 5/6 allow return to operation
// [RQ7] shutdown code: immediate or slow then disabled
// [RQ8] disable code: immediate or slow then disabled
// [RQ9] halt code acts while control bit 8 set
// [RQ10] halt 1 slow ramp, 2 quick ramp
// [RQ11] fault stops motor by fault code
// [RQ12] fault 0 immediate, 1 slow, 2 quick
// [RQ13] reserved codes rejected, old value kept
module dsos_selector (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // register port
    input wire dsos_pkg::dsos_bus_t i_bus,
    output logic [31:0] o_rdata,
    // power state machine events and control word
    input wire dsos_pkg::dsos_evt_t i_evt,
    input wire logic [15:0] i_ctrl_word,
    input wire logic i_standstill,
    // speed conversion
    input wire logic i_speed_start,
    input wire logic signed [31:0] i_speed_internal,
    output logic o_speed_busy,
    output logic o_speed_done,
    output logic signed [31:0] o_speed_user,
    // selected stop action
    output dsos_pkg::dsos_act_t o_act,
    output logic o_halt_active,
    output logic o_stop_active,
    output logic o_enter_disabled
);
    import dsos_pkg::*;

    logic [15:0] qstop_code;
    logic [15:0] shut_code;
    logic [15:0] dis_code;
    logic [15:0] halt_code;
    logic [15:0] fault_code;
    logic signed [31:0] spd_num;
    logic signed [31:0] spd_den;
    logic [15:0] word_idx;
    logic idx_ok;
    logic sel_qstop;
    logic sel_shut;
    logic sel_dis;
    logic sel_halt;
    logic sel_fault;
    logic sel_num;
    logic sel_den;
    dsos_act_t next_act;
    dsos_act_t act_hold;
    logic evt_any;
    logic stop_active;
    logic [15:0] ctrl_sync1;
    logic [15:0] ctrl_sync2;
    dsos_evt_t evt_sync1;
    dsos_evt_t evt_sync2;
    dsos_evt_t evt_prev;
    dsos_evt_t evt_rise;
    logic stand_sync1;
    logic stand_sync2;
    logic [31:0] next_rdata;

    // register decode, byte address is four times the index
    assign word_idx = i_bus.addr[17:2];
    assign idx_ok = (i_bus.addr[1:0] == 2'h0);
    assign sel_qstop = idx_ok && (word_idx == `DSOS_IDX_QSTOP);
    assign sel_shut = idx_ok && (word_idx == `DSOS_IDX_SHUT);
    assign sel_dis = idx_ok && (word_idx == `DSOS_IDX_DIS);
    assign sel_halt = idx_ok && (word_idx == `DSOS_IDX_HALT);
    assign sel_fault = idx_ok && (word_idx == `DSOS_IDX_FAULT);
    assign sel_num = idx_ok && (word_idx == `DSOS_IDX_SPD_NUM);
    assign sel_den = idx_ok && (word_idx == `DSOS_IDX_SPD_DEN);

    // pin synchronisers
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ctrl_sync1 <= '0;
            ctrl_sync2 <= '0;
        end else begin
            ctrl_sync1 <= i_ctrl_word;
            ctrl_sync2 <= ctrl_sync1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            evt_sync1 <= '0;
            evt_sync2 <= '0;
            evt_prev <= '0;
        end else begin
            evt_sync1 <= i_evt;
            evt_sync2 <= evt_sync1;
            evt_prev <= evt_sync2;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            stand_sync1 <= 1'b0;
            stand_sync2 <= 1'b0;
        end else begin
            stand_sync1 <= i_standstill;
            stand_sync2 <= stand_sync1;
        end
    end

    assign evt_rise = evt_sync2 & ~evt_prev;
    assign evt_any = |evt_rise;

    // option code registers, reserved values refused
    dsos_code_reg #(
        .RESET_VAL(`DSOS_RST_QSTOP),
        .VALID_MASK(7'h67)
    ) u_qstop (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_wr(i_bus.wr && sel_qstop),
        .i_wdata(i_bus.wdata[15:0]),
        .o_code(qstop_code)
    );

    dsos_code_reg #(
        .RESET_VAL(`DSOS_RST_SHUT),
        .VALID_MASK(7'h03)
    ) u_shut (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_wr(i_bus.wr && sel_shut),
        .i_wdata(i_bus.wdata[15:0]),
        .o_code(shut_code)
    );

    dsos_code_reg #(
        .RESET_VAL(`DSOS_RST_DIS),
        .VALID_MASK(7'h03)
    ) u_dis (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_wr(i_bus.wr && sel_dis),
        .i_wdata(i_bus.wdata[15:0]),
        .o_code(dis_code)
    );

    dsos_code_reg #(
        .RESET_VAL(`DSOS_RST_HALT),
        .VALID_MASK(7'h06)
    ) u_halt (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_wr(i_bus.wr && sel_halt),
        .i_wdata(i_bus.wdata[15:0]),
        .o_code(halt_code)
    );

    dsos_code_reg #(
        .RESET_VAL(`DSOS_RST_FAULT),
        .VALID_MASK(7'h07)
    ) u_fault (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_wr(i_bus.wr && sel_fault),
        .i_wdata(i_bus.wdata[15:0]),
        .o_code(fault_code)
    );

    // speed factor registers
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            spd_num <= `DSOS_RST_SPD_NUM;
        end else if (i_bus.wr && sel_num) begin
            spd_num <= i_bus.wdata; // RQ1
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            spd_den <= `DSOS_RST_SPD_DEN;
        end else if (i_bus.wr && sel_den) begin
            spd_den <= i_bus.wdata; // RQ1
        end
    end

    dsos_speed_conv #(
        .W(32)
    ) u_conv (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_start(i_speed_start),
        .i_value(i_speed_internal),
        .i_num(spd_num),
        .i_den(spd_den),
        .o_busy(o_speed_busy),
        .o_done(o_speed_done),
        .o_result(o_speed_user)
    );

    // read data, one cycle after the strobe
    always_comb begin
        next_rdata = '0;
        if (idx_ok) begin
            case (word_idx)
                `DSOS_IDX_QSTOP: next_rdata = {16'h0000, qstop_code};
                `DSOS_IDX_SHUT: next_rdata = {16'h0000, shut_code};
                `DSOS_IDX_DIS: next_rdata = {16'h0000, dis_code};
                `DSOS_IDX_HALT: next_rdata = {16'h0000, halt_code};
                `DSOS_IDX_FAULT: next_rdata = {16'h0000, fault_code};
                `DSOS_IDX_SPD_NUM: next_rdata = spd_num;
                `DSOS_IDX_SPD_DEN: next_rdata = spd_den;
                `DSOS_IDX_STATUS: next_rdata = {24'h000000,
                    act_hold.ramp, act_hold.final_state,
                    act_hold.energized, act_hold.allow_reenable,
                    o_halt_active, stop_active};
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_bus.rd ? next_rdata : '0;
        end
    end

    // action selection, fault highest priority
    always_comb begin
        next_act = act_hold;
        if (evt_rise.fault) begin
            case (fault_code) // RQ11
                `DSOS_CODE_IMM: next_act = '{DSOS_RAMP_IMM, DSOS_END_NONE,
                    1'b0, 1'b0}; // RQ12
                `DSOS_CODE_SLOW: next_act = '{DSOS_RAMP_SLOW, DSOS_END_NONE,
                    1'b1, 1'b0}; // RQ12
                default: next_act = '{DSOS_RAMP_QUICK, DSOS_END_NONE,
                    1'b1, 1'b0}; // RQ12
            endcase
        end else if (evt_rise.qstop) begin
            case (qstop_code)
                `DSOS_CODE_IMM: next_act = '{DSOS_RAMP_IMM, DSOS_END_SOD,
                    1'b0, 1'b0}; // RQ2
                `DSOS_CODE_SLOW: next_act = '{DSOS_RAMP_SLOW, DSOS_END_SOD,
                    1'b1, 1'b0}; // RQ3
                `DSOS_CODE_SLOW_HOLD: next_act = '{DSOS_RAMP_SLOW,
                    DSOS_END_QSA, 1'b1, 1'b1}; // RQ5 RQ6
                `DSOS_CODE_QUICK_HOLD: next_act = '{DSOS_RAMP_QUICK,
                    DSOS_END_QSA, 1'b1, 1'b1}; // RQ5 RQ6
                default: next_act = '{DSOS_RAMP_QUICK, DSOS_END_SOD,
                    1'b1, 1'b0}; // RQ4
            endcase
        end else if (evt_rise.shutdown) begin
            next_act = (shut_code == `DSOS_CODE_IMM)
                ? '{DSOS_RAMP_IMM, DSOS_END_SOD, 1'b0, 1'b0}
                : '{DSOS_RAMP_SLOW, DSOS_END_SOD, 1'b1, 1'b0}; // RQ7
        end else if (evt_rise.disable_op) begin
            next_act = (dis_code == `DSOS_CODE_IMM)
                ? '{DSOS_RAMP_IMM, DSOS_END_SOD, 1'b0, 1'b0}
                : '{DSOS_RAMP_SLOW, DSOS_END_SOD, 1'b1, 1'b0}; // RQ8
        end else if (!stop_active) begin
            if (ctrl_sync2[`DSOS_CW_HALT_BIT]) begin // RQ9
                next_act = (halt_code == `DSOS_CODE_SLOW)
                    ? '{DSOS_RAMP_SLOW, DSOS_END_NONE, 1'b1, 1'b1}
                    : '{DSOS_RAMP_QUICK, DSOS_END_NONE, 1'b1, 1'b1}; // RQ10
            end else begin
                next_act = '{DSOS_RAMP_NONE, DSOS_END_NONE, 1'b1, 1'b0};
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            act_hold <= '{DSOS_RAMP_NONE, DSOS_END_NONE, 1'b1, 1'b0};
        end else begin
            act_hold <= next_act;
        end
    end

    // stop in progress until standstill
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            stop_active <= 1'b0;
        end else if (evt_any) begin
            stop_active <= 1'b1;
        end else if (stand_sync2 && stop_active) begin
            stop_active <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_enter_disabled <= 1'b0;
        end else begin
            o_enter_disabled <= stop_active && stand_sync2 && !evt_any
                && act_hold.final_state == DSOS_END_SOD; // RQ2 RQ3 RQ4
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_halt_active <= 1'b0;
        end else begin
            o_halt_active <= !stop_active && !evt_any
                && ctrl_sync2[`DSOS_CW_HALT_BIT]; // RQ9
        end
    end

    assign o_act = act_hold;
    assign o_stop_active = stop_active;
endmodule : dsos_selector

// File: rtl/dsos_speed_conv.sv
module dsos_speed_conv #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // operands
    input wire logic i_start,
    input wire logic signed [W-1:0] i_value,
    input wire logic signed [W-1:0] i_num,
    input wire logic signed [W-1:0] i_den,
    // result
    output logic o_busy,
    output logic o_done,
    output logic signed [W-1:0] o_result
);
    logic [2*W-1:0] rem;
    logic [2*W-1:0] quo;
    logic [2*W-1:0] dvs;
    logic neg;
    logic [$clog2(2*W+1)-1:0] cnt;
    logic [2*W-1:0] prod_abs;
    logic signed [2*W-1:0] prod;
    logic [W-1:0] den_abs;

    if (W < 2) begin : g_width_check
        $error("dsos_speed_conv: W too small");
    end

    always_comb begin
        prod = (2*W)'(i_value) * (2*W)'(i_num);
        prod_abs = prod[2*W-1] ? (2*W)'(-prod) : prod;
        den_abs = i_den[W-1] ? W'(-i_den) : i_den;
    end

    // restoring division of |value*num| by |den|
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            rem <= '0;
            quo <= '0;
            dvs <= '0;
            neg <= 1'b0;
            cnt <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_result <= '0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !o_busy) begin
                rem <= '0;
                quo <= prod_abs;
                dvs <= {{W{1'b0}}, den_abs};
                neg <= prod[2*W-1] ^ i_den[W-1];
                cnt <= ($clog2(2*W+1))'(2 * W);
                o_busy <= 1'b1;
            end else if (o_busy) begin
                if (cnt == '0) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    if (dvs == '0) begin
                        o_result <= '0;
                    end else begin
                        o_result <= neg ? W'(-quo) : quo[W-1:0]; // RQ1
                    end
                end else begin
                    cnt <= cnt - 1'b1;
                    if ({rem[2*W-2:0], quo[2*W-1]} >= dvs) begin
                        rem <= {rem[2*W-2:0], quo[2*W-1]} - dvs;
                        quo <= {quo[2*W-2:0], 1'b1};
                    end else begin
                        rem <= {rem[2*W-2:0], quo[2*W-1]};
                        quo <= {quo[2*W-2:0], 1'b0};
                    end
                end
            end
        end
    end
endmodule : dsos_speed_conv
